// >>> rtl/ssl_pkg.sv
// constants for the synthesizer serial latch and lock detect block
package ssl_pkg;
	// ----------------------------------------------------------------
	// serial word and latch select
	// ----------------------------------------------------------------
	localparam int         WORD_W      = 24;
	localparam int         SEL_LSB     = 0;
	localparam logic [1:0] SEL_REF     = 2'h0;
	localparam logic [1:0] SEL_FB      = 2'h1;
	localparam logic [1:0] SEL_FUNC    = 2'h2;
	localparam logic [1:0] SEL_INIT    = 2'h3;
	localparam logic [WORD_W-1:0] LATCH_RST = 24'h000000;

	// ----------------------------------------------------------------
	// reference divider latch fields
	// ----------------------------------------------------------------
	localparam int REF_DIV_LSB = 2;
	localparam int REF_DIV_W   = 14;
	localparam int ABW_LSB     = 16;
	localparam int LOCK_PREC_B = 20;
	localparam int PRE_DELAY_B = 22;

	// ----------------------------------------------------------------
	// feedback counter latch fields
	// ----------------------------------------------------------------
	localparam int SWAL_LSB    = 2;
	localparam int SWAL_W      = 6;
	localparam int MAIN_LSB    = 8;
	localparam int MAIN_W      = 13;
	localparam int GAIN_B      = 21;
	localparam int FB_DIV_W    = 20;
	localparam logic [MAIN_W-1:0] MAIN_MIN = 13'h0003;

	// ----------------------------------------------------------------
	// function and initialization latch fields
	// ----------------------------------------------------------------
	localparam int OSEL_LSB    = 4;
	localparam int PD_LOW_B    = 3;
	localparam int PD_HIGH_B   = 21;
	localparam int PRE_LSB     = 22;
	localparam logic [6:0] PRE_MOD_8  = 7'h08;
	localparam logic [6:0] PRE_MOD_16 = 7'h10;
	localparam logic [6:0] PRE_MOD_32 = 7'h20;
	localparam logic [6:0] PRE_MOD_64 = 7'h40;

	// ----------------------------------------------------------------
	// output multiplexer selections
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OSEL_LOW     = 3'h0,
		OSEL_DLOCK   = 3'h1,
		OSEL_FB_OUT  = 3'h2,
		OSEL_HIGH    = 3'h3,
		OSEL_REF_OUT = 3'h4,
		OSEL_ALOCK   = 3'h5,
		OSEL_SDATA   = 3'h6,
		OSEL_GND     = 3'h7
	} ssl_osel_t;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 100000;
	localparam int LOCK_WIN_PS   = 15000;
	localparam int UNLOCK_PS     = 25000;
	localparam int LOCK_CNT_LO   = 3;
	localparam int LOCK_CNT_HI   = 5;
	localparam int ABW_00_PS     = 3000;
	localparam int ABW_01_PS     = 1500;
	localparam int ABW_10_PS     = 6000;
	localparam int ABW_11_PS     = 3000;
	localparam int ABW_00_RAW = (ABW_00_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ABW_01_RAW = (ABW_01_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ABW_10_RAW = (ABW_10_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ABW_11_RAW = (ABW_11_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [3:0] ABW_00_CYC = 4'((ABW_00_RAW < 1) ? 1 : ABW_00_RAW);
	localparam logic [3:0] ABW_01_CYC = 4'((ABW_01_RAW < 1) ? 1 : ABW_01_RAW);
	localparam logic [3:0] ABW_10_CYC = 4'((ABW_10_RAW < 1) ? 1 : ABW_10_RAW);
	localparam logic [3:0] ABW_11_CYC = 4'((ABW_11_RAW < 1) ? 1 : ABW_11_RAW);
	localparam int ERR_W = 8;
endpackage

// >>> rtl/ssl_divider.sv
// programmable edge divider emitting one pulse per ratio input ticks
`timescale 1ns/1ps
module ssl_divider #(
	parameter int W = 14
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	// control
	input  wire logic         clear_i,
	input  wire logic [W-1:0] ratio_i,
	// count input and result
	input  wire logic         tick_i,
	output logic              pulse_o
);
	logic [W-1:0] cnt_r;

	// count ticks, ratio of zero or one divides by one
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cnt_r   <= '0;
			pulse_o <= 1'b0;
		end else if (clear_i) begin
			cnt_r   <= '0;
			pulse_o <= 1'b0;
		end else if (tick_i) begin
			if ((cnt_r + W'(1)) >= ratio_i) begin
				cnt_r   <= '0;
				pulse_o <= 1'b1;
			end else begin
				cnt_r   <= cnt_r + W'(1);
				pulse_o <= 1'b0;
			end
		end else begin
			pulse_o <= 1'b0;
		end
	end
endmodule // ssl_divider

// >>> rtl/ssl_top.sv
// synthesizer serial latches, dividers, phase comparator and lock detect
//
// Overview of operation
// - data enters MSB first, one bit per rising serial clock edge, 24 bits.
// - rising load strobe copies the shift register into exactly one latch.
// - the two lowest word bits pick the destination latch.
// - 00 reference, 01 feedback, 10 function, 11 initialization latch.
// - 14-bit reference divider, 19-bit feedback of 6-bit swallow, 13-bit main.
// - comparator compares reference output with feedback output, ratio main*P+swallow.
// - comparator has antibacklash width from two latch bits, one core cycle at every setting.
// - antibacklash width bits come only from the reference divider latch.
// - three-bit output select in the function latch picks the muxed node.
// - muxed output may show digital or analog lock indication.
// - precision zero: lock after three consecutive cycles under 15 ns error.
// - precision one: lock after five consecutive cycles under 15 ns error.
// - lock stays high until a cycle shows error above 25 ns or the initialization latch is written.
// - analog lock rests high with narrow low-going pulses when locked.
// - reference ratios one through 16383 are accepted.
// - main counter ratios three through 8191 are accepted.
// - swallow counter values zero through 63 are accepted.
// - prescaler selectable among 8/9, 16/17, 32/33 and 64/65.
`timescale 1ns/1ps
module ssl_top
	import ssl_pkg::*;
(
	// clock and reset
	input  wire logic core_clk_i,
	input  wire logic resetn_i,
	// three-wire serial link
	input  wire logic serial_clk_i,
	input  wire logic serial_data_i,
	input  wire logic load_strobe_i,
	// divider inputs
	input  wire logic ref_in_i,
	input  wire logic rf_in_i,
	// charge pump drive
	output logic      pump_up_o,
	output logic      pump_dn_o,
	output logic      pump_gain_sel_o,
	output logic      prescaler_delay_enable_o,
	output logic [1:0] power_down_o,
	// multiplexed output, open drain only in analog lock mode
	output logic      muxout_o,
	output logic      muxout_oe_o
);
	// ----------------------------------------------------------------
	// pin synchronisers and edge detection
	// ----------------------------------------------------------------
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	logic [4:0] prev_r;
	logic [4:0] rise;

	// two flops per pin, then a delay stage for edges
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_r <= 5'h00;
			sync2_r <= 5'h00;
			prev_r  <= 5'h00;
		end else begin
			sync1_r <= {rf_in_i, ref_in_i, load_strobe_i, serial_data_i, serial_clk_i};
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	assign rise = sync2_r & ~prev_r;

	// ----------------------------------------------------------------
	// input shift register and latches
	// ----------------------------------------------------------------
	logic [WORD_W-1:0] shift_r;
	logic [WORD_W-1:0] ref_latch_r;
	logic [WORD_W-1:0] fb_latch_r;
	logic [WORD_W-1:0] func_latch_r;
	logic [WORD_W-1:0] init_latch_r;
	logic              use_init_r;
	logic              init_clear_r;
	logic [WORD_W-1:0] func_eff;

	// shift in msb first, oldest bits fall off the top
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shift_r <= LATCH_RST;
		end else if (rise[0]) begin
			shift_r <= {shift_r[WORD_W-2:0], sync2_r[1]};
		end
	end

	// strobe edge writes one latch chosen by the low bits
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ref_latch_r  <= LATCH_RST;
			fb_latch_r   <= LATCH_RST;
			func_latch_r <= LATCH_RST;
			init_latch_r <= LATCH_RST;
			use_init_r   <= 1'b0;
			init_clear_r <= 1'b0;
		end else begin
			init_clear_r <= 1'b0;
			if (rise[2]) begin
				case (shift_r[SEL_LSB+1:SEL_LSB])
					SEL_REF: begin
						ref_latch_r <= shift_r;
					end
					SEL_FB: begin
						fb_latch_r <= shift_r;
					end
					SEL_FUNC: begin
						func_latch_r <= shift_r;
						use_init_r   <= 1'b0;
					end
					SEL_INIT: begin
						init_latch_r <= shift_r;
						use_init_r   <= 1'b1;
						init_clear_r <= 1'b1;
					end
					default: begin
						ref_latch_r <= ref_latch_r;
					end
				endcase
			end
		end
	end

	// function settings follow whichever of the two latches came last
	assign func_eff = use_init_r ? init_latch_r : func_latch_r;

	// ----------------------------------------------------------------
	// dividers
	// ----------------------------------------------------------------
	logic [REF_DIV_W-1:0] ref_ratio;
	logic [MAIN_W-1:0]    main_raw;
	logic [MAIN_W-1:0]    main_eff;
	logic [SWAL_W-1:0]    swal;
	logic [6:0]           pre_mod;
	logic [FB_DIV_W-1:0]  fb_ratio;
	logic                 ref_pulse;
	logic                 fb_pulse;

	assign ref_ratio = ref_latch_r[REF_DIV_LSB +: REF_DIV_W];
	assign main_raw  = fb_latch_r[MAIN_LSB +: MAIN_W];
	assign main_eff  = (main_raw < MAIN_MIN) ? MAIN_MIN : main_raw;
	assign swal      = fb_latch_r[SWAL_LSB +: SWAL_W];

	// prescaler modulus from the two ratio bits
	always_comb begin
		case (func_eff[PRE_LSB+1:PRE_LSB])
			2'h0:    pre_mod = PRE_MOD_8;
			2'h1:    pre_mod = PRE_MOD_16;
			2'h2:    pre_mod = PRE_MOD_32;
			default: pre_mod = PRE_MOD_64;
		endcase
	end

	// total feedback ratio, main times modulus plus swallow
	assign fb_ratio = FB_DIV_W'(FB_DIV_W'(main_eff) * FB_DIV_W'(pre_mod)) + FB_DIV_W'(swal);

	// reference divider
	ssl_divider #(.W(REF_DIV_W)) u_ref_div (
		.clk_i    (core_clk_i),
		.resetn_i (resetn_i),
		.clear_i  (init_clear_r),
		.ratio_i  (ref_ratio),
		.tick_i   (rise[3]),
		.pulse_o  (ref_pulse)
	);

	// feedback divider
	ssl_divider #(.W(FB_DIV_W)) u_fb_div (
		.clk_i    (core_clk_i),
		.resetn_i (resetn_i),
		.clear_i  (init_clear_r),
		.ratio_i  (fb_ratio),
		.tick_i   (rise[4]),
		.pulse_o  (fb_pulse)
	);

	// ----------------------------------------------------------------
	// phase comparator with antibacklash
	// ----------------------------------------------------------------
	logic [3:0]       abw_len;
	logic [3:0]       abw_cnt_r;
	logic [ERR_W-1:0] err_cnt_r;
	logic             pd_done;

	// width from reference latch bits only
	always_comb begin
		case (ref_latch_r[ABW_LSB+1:ABW_LSB])
			2'h0:    abw_len = ABW_00_CYC;
			2'h1:    abw_len = ABW_01_CYC;
			2'h2:    abw_len = ABW_10_CYC;
			default: abw_len = ABW_11_CYC;
		endcase
	end

	// one cycle mark at the start of the overlap ends each comparison
	assign pd_done = pump_up_o & pump_dn_o & (abw_cnt_r == 4'h0);

	// up on reference edge, down on feedback edge, both clear after width
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pump_up_o <= 1'b0;
			pump_dn_o <= 1'b0;
			abw_cnt_r <= 4'h0;
		end else if (init_clear_r) begin
			pump_up_o <= 1'b0;
			pump_dn_o <= 1'b0;
			abw_cnt_r <= 4'h0;
		end else if (pump_up_o && pump_dn_o) begin
			if ((abw_cnt_r + 4'h1) >= abw_len) begin
				pump_up_o <= 1'b0;
				pump_dn_o <= 1'b0;
				abw_cnt_r <= 4'h0;
			end else begin
				abw_cnt_r <= abw_cnt_r + 4'h1;
			end
		end else begin
			pump_up_o <= pump_up_o | ref_pulse;
			pump_dn_o <= pump_dn_o | fb_pulse;
		end
	end

	// phase error in cycles while only one side is raised
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			err_cnt_r <= '0;
		end else if (pd_done || init_clear_r) begin
			err_cnt_r <= '0;
		end else if ((pump_up_o ^ pump_dn_o) && (err_cnt_r != '1)) begin
			err_cnt_r <= err_cnt_r + ERR_W'(1);
		end
	end

	// ----------------------------------------------------------------
	// digital lock detect
	// ----------------------------------------------------------------
	logic [2:0] good_cnt_r;
	logic       dlock_r;
	logic [2:0] need_cnt;
	logic       err_small;
	logic       err_large;

	assign need_cnt  = ref_latch_r[LOCK_PREC_B] ? 3'(LOCK_CNT_HI) : 3'(LOCK_CNT_LO);
	assign err_small = (int'(err_cnt_r) * CLK_PERIOD_PS) < LOCK_WIN_PS;
	assign err_large = (int'(err_cnt_r) * CLK_PERIOD_PS) > UNLOCK_PS;

	// count consecutive good cycles, drop only on a large error or an init latch write
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			good_cnt_r <= 3'h0;
			dlock_r    <= 1'b0;
		end else if (init_clear_r) begin
			good_cnt_r <= 3'h0;
			dlock_r    <= 1'b0;
		end else if (pd_done) begin
			if (err_large) begin
				good_cnt_r <= 3'h0;
				dlock_r    <= 1'b0;
			end else if (err_small) begin
				if ((good_cnt_r + 3'h1) >= need_cnt) begin
					dlock_r <= 1'b1;
				end else begin
					good_cnt_r <= good_cnt_r + 3'h1;
				end
			end else begin
				good_cnt_r <= 3'h0;
			end
		end
	end

	// ----------------------------------------------------------------
	// output multiplexer and static controls
	// ----------------------------------------------------------------
	ssl_osel_t osel;

	assign osel = ssl_osel_t'(func_eff[OSEL_LSB +: 3]);

	// registered node selection, open drain for analog lock
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			muxout_o    <= 1'b0;
			muxout_oe_o <= 1'b1;
		end else begin
			muxout_oe_o <= 1'b1;
			case (osel)
				OSEL_LOW:     muxout_o <= 1'b0;
				OSEL_DLOCK:   muxout_o <= dlock_r;
				OSEL_FB_OUT:  muxout_o <= fb_pulse;
				OSEL_HIGH:    muxout_o <= 1'b1;
				OSEL_REF_OUT: muxout_o <= ref_pulse;
				OSEL_ALOCK: begin
					muxout_o    <= 1'b0;
					muxout_oe_o <= pump_up_o | pump_dn_o;
				end
				OSEL_SDATA:   muxout_o <= shift_r[WORD_W-1];
				default:      muxout_o <= 1'b0;
			endcase
		end
	end

	// latched control bits passed to the analog side
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pump_gain_sel_o          <= 1'b0;
			prescaler_delay_enable_o <= 1'b0;
			power_down_o             <= 2'h0;
		end else begin
			pump_gain_sel_o          <= fb_latch_r[GAIN_B];
			prescaler_delay_enable_o <= ref_latch_r[PRE_DELAY_B];
			power_down_o             <= {func_eff[PD_HIGH_B], func_eff[PD_LOW_B]};
		end
	end
endmodule // ssl_top

// >>> bench/ssl_props.sv
// checker on the ports of the serial latch and lock detect block
`timescale 1ns/1ps
module ssl_props (
	// clock and reset
	input  wire logic       core_clk_i,
	input  wire logic       resetn_i,
	// watched ports
	input  wire logic       load_strobe_i,
	input  wire logic       pump_up_o,
	input  wire logic       pump_dn_o,
	input  wire logic       pump_gain_sel_o,
	input  wire logic       prescaler_delay_enable_o,
	input  wire logic [1:0] power_down_o,
	input  wire logic       muxout_o,
	input  wire logic       muxout_oe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!resetn_i);
	logic       strobe_q_r;
	logic [3:0] age_r;
	// cycles since the last strobe rise, saturating
	always_ff @(posedge core_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			strobe_q_r <= 1'b0;
			age_r      <= 4'hF;
		end else begin
			strobe_q_r <= load_strobe_i;
			if (load_strobe_i && !strobe_q_r) age_r <= 4'h0;
			else if (age_r != 4'hF) age_r <= age_r + 4'h1;
		end
	end
	property p_ab_release;
		pump_up_o && pump_dn_o |=> !pump_up_o && !pump_dn_o;
	endproperty
	a_ab_release: assert property (p_ab_release) else $error("pumps stay after overlap");
	property p_fall_pair;
		$fell(pump_up_o) |-> $fell(pump_dn_o);
	endproperty
	a_fall_pair: assert property (p_fall_pair) else $error("pumps fall apart");
	property p_up_hold;
		pump_up_o && !pump_dn_o |=> pump_up_o;
	endproperty
	a_up_hold: assert property (p_up_hold) else $error("up pump dropped alone");
	property p_dn_hold;
		pump_dn_o && !pump_up_o |=> pump_dn_o;
	endproperty
	a_dn_hold: assert property (p_dn_hold) else $error("down pump dropped alone");
	property p_gain;
		$changed(pump_gain_sel_o) |-> age_r <= 4'h6;
	endproperty
	a_gain: assert property (p_gain) else $error("gain changed without strobe");
	property p_delay;
		$changed(prescaler_delay_enable_o) |-> age_r <= 4'h6;
	endproperty
	a_delay: assert property (p_delay) else $error("delay bit changed without strobe");
	property p_pd;
		$changed(power_down_o) |-> age_r <= 4'h6;
	endproperty
	a_pd: assert property (p_pd) else $error("power down changed without strobe");
	property p_rel;
		$rose(resetn_i) |-> !pump_up_o && !pump_dn_o && muxout_oe_o && !muxout_o;
	endproperty
	a_rel: assert property (p_rel) else $error("outputs wrong after reset");
endmodule // ssl_props

// >>> bench/ssl_host_model.sv
// three-wire serial host model driving the latch link
`timescale 1ns/1ps
module ssl_host_model (
	// timing reference
	input  wire logic core_clk_i,
	// link pins
	output logic      serial_clk_o,
	output logic      serial_data_o,
	output logic      load_strobe_o
);
	// idle link levels
	initial begin
		serial_clk_o  = 1'b0;
		serial_data_o = 1'b0;
		load_strobe_o = 1'b0;
	end
	// one bit, 800 ns link period, entered at a falling core edge
	task automatic bit_out(input logic b);
		serial_data_o = b;
		repeat (4) @(negedge core_clk_i);
		serial_clk_o = 1'b1;
		repeat (4) @(negedge core_clk_i);
		serial_clk_o = 1'b0;
	endtask
	// whole word then strobe pulse
	task automatic word_out(input logic [23:0] w);
		for (int i = 23; i >= 0; i--) bit_out(w[i]);
		serial_data_o = ~w[0]; // data no longer held
		repeat (4) @(negedge core_clk_i);
		load_strobe_o = 1'b1;
		repeat (4) @(negedge core_clk_i);
		load_strobe_o = 1'b0;
		repeat (4) @(negedge core_clk_i);
	endtask
endmodule // ssl_host_model

// >>> bench/ssl_top_tb_top.sv
// testbench for the serial latch and lock detect block
`timescale 1ns/1ps
module ssl_top_tb_top import ssl_pkg::*;;
	typedef struct {logic [WORD_W-1:0] word; logic [4:0] exp;} ssl_row_t;
	logic       core_clk;
	logic       resetn;
	logic       ref_in;
	logic       rf_in;
	wire logic  sclk;
	wire logic  sdata;
	wire logic  strobe;
	wire logic  up;
	wire logic  dn;
	wire logic  gain;
	wire logic  pre_delay;
	wire logic [1:0] pd;
	wire logic  mux;
	wire logic  mux_oe;
	wire logic  mux_lvl;
	wire logic [4:0] outs;
	int         errors = 0;
	int         checks = 0;
	int         lows = 0;
	int         lows0;
	int         ticks = 24;
	// {gain, delay, power down, mux level} per written word
	ssl_row_t   rows [6] = '{
		'{24'h400000, 5'b01000}, '{24'h200301, 5'b11000},
		'{24'h20003A, 5'b11111}, '{24'h000003, 5'b11000},
		'{24'h000004, 5'b10000}, '{24'h000012, 5'b10000}};
	// open-drain level with pull-up
	assign mux_lvl = mux_oe ? mux : 1'b1;
	assign outs    = {gain, pre_delay, pd, mux_lvl};
	ssl_top i_ssl_top (
		.core_clk_i(core_clk), .resetn_i(resetn), .serial_clk_i(sclk),
		.serial_data_i(sdata), .load_strobe_i(strobe), .ref_in_i(ref_in),
		.rf_in_i(rf_in), .pump_up_o(up), .pump_dn_o(dn), .pump_gain_sel_o(gain),
		.prescaler_delay_enable_o(pre_delay), .power_down_o(pd), .muxout_o(mux),
		.muxout_oe_o(mux_oe));
	ssl_host_model host (
		.core_clk_i(core_clk), .serial_clk_o(sclk), .serial_data_o(sdata),
		.load_strobe_o(strobe));
	// 10 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// low samples of the open-drain level, for the analog lock pulses
	always @(negedge core_clk) begin
		if (mux_lvl === 1'b0) lows++;
	end
	// compare and count
	task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected %s: expected %b seen %b", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// n comparison periods of ticks feedback ticks, reference tick in slot rs
	task automatic run_pd(input int n, input int rs);
		for (int p = 0; p < n; p++) begin
			for (int s = 1; s <= rs || s <= ticks; s++) begin
				rf_in  = (s <= ticks);
				ref_in = (s == rs);
				@(negedge core_clk);
				rf_in  = 1'b0;
				ref_in = 1'b0;
				@(negedge core_clk);
			end
		end
		repeat (10) @(negedge core_clk);
	endtask
	// watchdog
	initial begin
		#2000000;
		errors++;
		give_verdict();
	end
	// main sequence
	initial begin
		resetn = 1'b0;
		ref_in = 1'b0;
		rf_in  = 1'b0;
		repeat (6) @(negedge core_clk);
		resetn = 1'b1;
		@(negedge core_clk);
		check("reset", outs, 5'b00000);
		for (int i = 0; i < 6; i++) begin
			host.word_out(rows[i].word);
			check("latch", outs, rows[i].exp);
		end
		run_pd(2, 24);
		check("lock2", outs, 5'b10000);
		run_pd(1, 24);
		check("lock3", outs, 5'b10001);
		run_pd(1, 24);
		check("hold", outs, 5'b10001);
		run_pd(1, 23);
		check("early", outs, 5'b10000);
		host.word_out(24'h100004);
		run_pd(4, 24);
		check("lock4", outs, 5'b10000);
		run_pd(1, 24);
		check("lock5", outs, 5'b10001);
		run_pd(1, 25);
		check("late", outs, 5'b10000);
		for (int i = 0; i < 24; i++) host.bit_out(1'b1);
		repeat (8) @(negedge core_clk);
		check("noload", outs, 5'b10000);
		host.bit_out(1'b1);
		host.bit_out(1'b1);
		host.word_out(24'h000301);
		check("last24", outs, 5'b00000);
		ticks = 53;
		host.word_out(24'h000315);
		host.word_out(24'h400012);
		run_pd(5, 53);
		check("modulus", outs, 5'b00001);
		host.word_out(24'h400052);
		check("alock_idle", outs, 5'b00001);
		lows0 = lows;
		run_pd(1, 53);
		check("alock_pulse", 5'(lows - lows0), 5'h01);
		host.word_out(24'hA00062);
		check("sdata", outs, 5'b00101);
		host.bit_out(1'b0);
		repeat (2) @(negedge core_clk);
		check("shift", outs, 5'b00100);
		resetn = 1'b0;
		repeat (2) @(negedge core_clk);
		resetn = 1'b1;
		@(negedge core_clk);
		check("rst2", outs, 5'b00000);
		check("pumps", {3'h0, up, dn}, 5'h00);
		give_verdict();
	end
endmodule // ssl_top_tb_top
bind ssl_top ssl_props i_ssl_props (
	.core_clk_i(core_clk_i), .resetn_i(resetn_i), .load_strobe_i(load_strobe_i),
	.pump_up_o(pump_up_o), .pump_dn_o(pump_dn_o), .pump_gain_sel_o(pump_gain_sel_o),
	.prescaler_delay_enable_o(prescaler_delay_enable_o), .power_down_o(power_down_o),
	.muxout_o(muxout_o), .muxout_oe_o(muxout_oe_o));
